//--- verilog/lcb_ctrl.v
// register file, lcd clock source selection, frame prescaler and bias /
// reference / contrast control of the segment lcd driver.
// assumes a waveform sequencer elsewhere consumes frame_tick and drives
// ladder_phase_b; the two oscillator inputs arrive asynchronously.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lcb_regs.vh"

module lcb_ctrl (
	// clock and reset
	input  wire        clock,
	input  wire        rst_n,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// clock sources and system state
	input  wire        crystal_osc_clock,
	input  wire        low_freq_internal_osc,
	input  wire        sleep_mode,
	input  wire        ladder_phase_b,
	// timing out
	output wire        frame_tick,
	output wire        driver_active,
	// reference and contrast control
	output wire        internal_ref_on,
	output wire        ref_from_fvr,
	output wire        ref_from_supply,
	output wire        bandgap_buf_en,
	output wire        fvr_buf_en,
	output wire        contrast_ladder_on,
	output wire [2:0]  contrast_select,
	// bias pins and ladder
	output wire [3:1]  bias_pin_connect,
	output wire [1:0]  ladder_power,
	output wire        ladder_mid_short,
	output wire [1:0]  bias_type,
	output wire [1:0]  commons_select,
	// pins and pixels
	output wire [15:0] segment_enable_bit,
	output wire [63:0] pixel_bit
);

	// ==========================================================
	// functions

	// keep only implemented bits of a register
	function [7:0] lcb_mask;
		input [7:0] val;
		input [7:0] msk;
		begin
			lcb_mask = val & msk;
		end
	endfunction

	// index of a pixel register, valid only inside its range
	function [2:0] lcb_pix_idx;
		input [3:0] a;
		reg   [3:0] d;
		begin
			d = a - `LCB_ADDR_PIX_FIRST;
			lcb_pix_idx = d[2:0];
		end
	endfunction

	// ==========================================================
	// registers

	reg  [7:0]  ref_ctrl_r;     // reference voltage control
	reg  [2:0]  contrast_r;     // contrast ladder tap
	reg  [15:0] seg_en_r;       // segment pin ownership
	reg  [7:0]  pixel_r [0:7];  // pixel data, not reset
	reg  [7:0]  clk_ctrl_r;     // enable, sleep disable, source, commons
	reg  [7:0]  phase_r;        // half bias and prescale select
	reg  [1:0]  ladder_r;       // ladder power mode
	reg  [3:0]  psc_cnt_r;      // hidden prescale counter
	reg  [3:0]  psc_sel_r;      // prescale ratio in use
	reg  [1:0]  src_sel_r;      // clock source in use
	reg  [7:0]  sys_div_r;      // fixed system clock divider
	reg  [1:0]  xtal_sync_r;    // crystal synchroniser
	reg  [1:0]  lfo_sync_r;     // low oscillator synchroniser
	reg         xtal_prev_r;    // crystal edge history
	reg         lfo_prev_r;     // low oscillator edge history
	reg         active_r;       // driver active status
	wire        pix_hit;        // address falls in pixel range
	wire        src_tick;       // one pulse per selected source clock
	wire        psc_wrap;       // prescaler end of count
	reg         sel_tick;       // combinational source pick

	assign pix_hit = (reg_addr >= `LCB_ADDR_PIX_FIRST) &&
		(reg_addr <= `LCB_ADDR_PIX_LAST);

	// ==========================================================
	// register writes

	// control registers reset; pixel storage keeps its contents
	always @(posedge clock) begin
		if (!rst_n) begin
			ref_ctrl_r <= `LCB_RST_REF_CTRL;
			contrast_r <= `LCB_RST_CONTRAST;
			seg_en_r   <= {`LCB_RST_SEG_EN, `LCB_RST_SEG_EN};
			clk_ctrl_r <= `LCB_RST_CLK_CTRL;
			phase_r    <= `LCB_RST_PHASE;
			ladder_r   <= `LCB_RST_LADDER;
		end else if (reg_wr) begin
			case (reg_addr)
				`LCB_ADDR_REF_CTRL: begin
					ref_ctrl_r <= lcb_mask(reg_wdata,
						`LCB_MASK_REF_CTRL);
				end
				`LCB_ADDR_CONTRAST: begin
					contrast_r <= reg_wdata[2:0];
				end
				`LCB_ADDR_SEG_EN0: begin
					seg_en_r[7:0] <= reg_wdata;
				end
				`LCB_ADDR_SEG_EN1: begin
					seg_en_r[15:8] <= reg_wdata;
				end
				`LCB_ADDR_CLK_CTRL: begin
					clk_ctrl_r <= lcb_mask(reg_wdata,
						`LCB_MASK_CLK_CTRL);
				end
				// status bit is not writable
				`LCB_ADDR_PHASE: begin
					phase_r <= lcb_mask(reg_wdata, `LCB_MASK_PHASE);
				end
				`LCB_ADDR_LADDER: begin
					ladder_r <= reg_wdata[1:0];
				end
				default: begin
					ladder_r <= ladder_r;
				end
			endcase
		end
	end

	always @(posedge clock) begin
		if (reg_wr && pix_hit) begin
			pixel_r[lcb_pix_idx(reg_addr)] <= reg_wdata;
		end
	end

	// ==========================================================
	// register reads

	// data valid in the cycle after the read strobe only
	always @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (pix_hit) begin
				reg_rdata <= pixel_r[lcb_pix_idx(reg_addr)];
			end else begin
				case (reg_addr)
					`LCB_ADDR_REF_CTRL: begin
						reg_rdata <= lcb_mask(ref_ctrl_r,
							`LCB_MASK_REF_CTRL);
					end
					`LCB_ADDR_CONTRAST: begin
						reg_rdata <= {5'h00, contrast_r};
					end
					`LCB_ADDR_SEG_EN0: begin
						reg_rdata <= seg_en_r[7:0];
					end
					`LCB_ADDR_SEG_EN1: begin
						reg_rdata <= seg_en_r[15:8];
					end
					`LCB_ADDR_CLK_CTRL: begin
						reg_rdata <= clk_ctrl_r;
					end
					`LCB_ADDR_PHASE: begin
						reg_rdata <= phase_r |
							({7'h00, active_r} << `LCB_PH_ACTIVE_BIT);
					end
					`LCB_ADDR_LADDER: begin
						reg_rdata <= {6'h00, ladder_r};
					end
					// unmapped reads as zero
					default: begin
						reg_rdata <= 8'h00;
					end
				endcase
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ==========================================================
	// driver activity

	// sleep only stops the driver when the sleep disable bit is set
	always @(posedge clock) begin
		if (!rst_n) begin
			active_r <= 1'b0;
		end else begin
			active_r <= clk_ctrl_r[`LCB_CLK_EN_BIT] &
				~(sleep_mode & clk_ctrl_r[`LCB_CLK_SLPDIS_BIT]);
		end
	end

	assign driver_active = active_r;

	// ==========================================================
	// clock sources

	// oscillator pins cross two flops before any edge detection
	always @(posedge clock) begin
		if (!rst_n) begin
			xtal_sync_r <= 2'b00;
			lfo_sync_r  <= 2'b00;
			xtal_prev_r <= 1'b0;
			lfo_prev_r  <= 1'b0;
		end else begin
			xtal_sync_r <= {xtal_sync_r[0], crystal_osc_clock};
			lfo_sync_r  <= {lfo_sync_r[0], low_freq_internal_osc};
			xtal_prev_r <= xtal_sync_r[1];
			lfo_prev_r  <= lfo_sync_r[1];
		end
	end

	// fixed divide, no register reaches it
	// it stops in sleep; the oscillator sources keep going
	always @(posedge clock) begin
		if (!rst_n) begin
			sys_div_r <= 8'h00;
		end else if (!sleep_mode) begin
			sys_div_r <= sys_div_r + 8'h01;
		end
	end

	// pick one tick per source period
	always @* begin
		case (src_sel_r)
			`LCB_SRC_SYSDIV: begin
				sel_tick = (sys_div_r == 8'hFF) & ~sleep_mode;
			end
			`LCB_SRC_XTAL: begin
				sel_tick = xtal_sync_r[1] & ~xtal_prev_r;
			end
			default: begin
				sel_tick = lfo_sync_r[1] & ~lfo_prev_r;
			end
		endcase
	end

	assign src_tick = sel_tick;

	// ==========================================================
	// frame prescaler

	// wrap after sel plus one source ticks
	assign psc_wrap = src_tick && (psc_cnt_r == psc_sel_r);

	// new ratio and source adopted only at wrap or while idle
	// so a mid-count change never gives a short frame
	always @(posedge clock) begin
		if (!rst_n) begin
			psc_cnt_r <= 4'h0;
			psc_sel_r <= 4'h0;
			src_sel_r <= `LCB_SRC_SYSDIV;
		end else if (!active_r) begin
			psc_cnt_r <= 4'h0;
			psc_sel_r <= phase_r[`LCB_PH_PSC_HI:`LCB_PH_PSC_LO];
			src_sel_r <= clk_ctrl_r[`LCB_CLK_SRC_HI:`LCB_CLK_SRC_LO];
		end else if (psc_wrap) begin
			psc_cnt_r <= 4'h0;
			psc_sel_r <= phase_r[`LCB_PH_PSC_HI:`LCB_PH_PSC_LO];
			src_sel_r <= clk_ctrl_r[`LCB_CLK_SRC_HI:`LCB_CLK_SRC_LO];
		end else if (src_tick) begin
			psc_cnt_r <= psc_cnt_r + 4'h1;
		end
	end

	// one-cycle pulse per frame clock
	assign frame_tick = psc_wrap & active_r;

	// ==========================================================
	// reference and contrast

	// reference follows enable, and only while active
	assign internal_ref_on = ref_ctrl_r[`LCB_REF_IRE_BIT] & active_r;
	// source select meaningful only with reference on
	assign ref_from_fvr    = internal_ref_on & ref_ctrl_r[`LCB_REF_IRS_BIT];
	assign ref_from_supply = internal_ref_on & ~ref_ctrl_r[`LCB_REF_IRS_BIT];
	// bandgap buffer off with the reference
	assign bandgap_buf_en  = internal_ref_on;
	// idle gate drops the buffer in power mode b
	assign fvr_buf_en = ref_from_fvr &
		~(ref_ctrl_r[`LCB_REF_IRI_BIT] & ladder_phase_b);
	assign contrast_ladder_on = internal_ref_on;
	// tap n gives n sevenths of full resistance
	assign contrast_select = contrast_r;

	// ==========================================================
	// bias pins and ladder

	// each pin joins its bias level when enabled
	// nothing here touches direction or analog select
	assign bias_pin_connect =
		ref_ctrl_r[`LCB_REF_B3_BIT:`LCB_REF_B1_BIT];
	assign ladder_power = active_r ? ladder_r : `LCB_PWR_OFF;
	// half bias shorts the middle resistor
	assign ladder_mid_short = phase_r[`LCB_PH_HALF_BIT] &
		(ladder_power != `LCB_PWR_OFF);
	assign commons_select =
		clk_ctrl_r[`LCB_CLK_MUX_HI:`LCB_CLK_MUX_LO];
	// static with one common, else half or third
	assign bias_type = (commons_select == 2'h0) ? `LCB_BIAS_STATIC :
		(phase_r[`LCB_PH_HALF_BIT] ? `LCB_BIAS_HALF : `LCB_BIAS_THIRD);

	// ==========================================================
	// pins and pixels

	// set bit hands the pin to the segment driver
	assign segment_enable_bit = seg_en_r;

	// flatten pixel store, register k at bits 8k+7..8k
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : pix_out
			assign pixel_bit[8*g+7:8*g] = pixel_r[g];
		end
	endgenerate

endmodule

`default_nettype wire

//--- inc/lcb_regs.vh
// register map, field positions, reset values and fixed counts of the
// lcd clock and bias control block.
// assumes an 8-bit register port with a 4-bit word address.
`ifndef LCB_REGS_VH
`define LCB_REGS_VH

// ==========================================================
// register offsets
`define LCB_ADDR_REF_CTRL   4'h0
`define LCB_ADDR_CONTRAST   4'h1
`define LCB_ADDR_SEG_EN0    4'h2
`define LCB_ADDR_SEG_EN1    4'h3
`define LCB_ADDR_PIX_FIRST  4'h4
`define LCB_ADDR_PIX_LAST   4'hB
`define LCB_ADDR_CLK_CTRL   4'hC
`define LCB_ADDR_PHASE      4'hD
`define LCB_ADDR_LADDER     4'hE

// ==========================================================
// implemented-bit masks (other bits read zero, except the phase status bit)
`define LCB_MASK_REF_CTRL   8'hEE
`define LCB_MASK_CONTRAST   8'h07
`define LCB_MASK_CLK_CTRL   8'hCF
`define LCB_MASK_PHASE      8'h4F
`define LCB_MASK_LADDER     8'h03

// ==========================================================
// field positions
`define LCB_REF_IRE_BIT     7
`define LCB_REF_IRS_BIT     6
`define LCB_REF_IRI_BIT     5
`define LCB_REF_B3_BIT      3
`define LCB_REF_B1_BIT      1
`define LCB_CLK_EN_BIT      7
`define LCB_CLK_SLPDIS_BIT  6
`define LCB_CLK_SRC_HI      3
`define LCB_CLK_SRC_LO      2
`define LCB_CLK_MUX_HI      1
`define LCB_CLK_MUX_LO      0
`define LCB_PH_HALF_BIT     6
`define LCB_PH_ACTIVE_BIT   5
`define LCB_PH_PSC_HI       3
`define LCB_PH_PSC_LO       0

// ==========================================================
// reset values
`define LCB_RST_REF_CTRL    8'h00
`define LCB_RST_CONTRAST    3'h0
`define LCB_RST_SEG_EN      8'h00
`define LCB_RST_CLK_CTRL    8'h03
`define LCB_RST_PHASE       8'h03
`define LCB_RST_LADDER      2'h0

// ==========================================================
// encodings and counts
`define LCB_SRC_SYSDIV      2'h0
`define LCB_SRC_XTAL        2'h1
`define LCB_SYS_DIV         9'h100
`define LCB_BIAS_STATIC     2'h0
`define LCB_BIAS_HALF       2'h1
`define LCB_BIAS_THIRD      2'h2
`define LCB_PWR_OFF         2'h0

`endif

//--- tb/lcb_ctrl_properties.sv
// port assertions for the lcd clock and bias control block.
// assumes it is bound to every lcb_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker on the top ports
module lcb_ctrl_props (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// register port
	input wire logic [3:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// derived controls
	input wire logic        frame_tick,
	input wire logic        driver_active,
	input wire logic        internal_ref_on,
	input wire logic        ref_from_fvr,
	input wire logic        ref_from_supply,
	input wire logic        bandgap_buf_en,
	input wire logic        fvr_buf_en,
	input wire logic        contrast_ladder_on,
	input wire logic [2:0]  contrast_select,
	input wire logic [1:0]  ladder_power,
	input wire logic        ladder_mid_short,
	input wire logic [1:0]  bias_type,
	input wire logic [15:0] segment_enable_bit
);
	// one domain, so one clock and one disable for all
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	ref_gate_a: assert property (internal_ref_on |-> driver_active)
		else $error("reference on while driver idle");
	src_excl_a: assert property (ref_from_fvr |-> !ref_from_supply)
		else $error("both reference sources chosen");
	ref_off_a: assert property (!internal_ref_on |->
		!bandgap_buf_en && !contrast_ladder_on && !fvr_buf_en)
		else $error("contrast powered without reference");
	idle_gate_a: assert property (fvr_buf_en |-> ref_from_fvr)
		else $error("fixed buffer on without fixed source");
	unimpl_ref_a: assert property (reg_rd && reg_addr == 4'h0 |=>
		reg_rdata[4] == 1'b0 && reg_rdata[0] == 1'b0)
		else $error("unused reference bits read one");
	contrast_wr_a: assert property (reg_wr && reg_addr == 4'h1 |=>
		contrast_select == $past(reg_wdata[2:0]))
		else $error("contrast tap not taken from write");
	seg_wr_a: assert property (reg_wr && reg_addr == 4'h2 |=>
		segment_enable_bit[7:0] == $past(reg_wdata))
		else $error("segment enables not taken from write");
	ladder_off_a: assert property (!driver_active |->
		ladder_power == 2'h0)
		else $error("ladder powered while idle");
	mid_short_a: assert property (ladder_mid_short |->
		bias_type == 2'h1 && ladder_power != 2'h0)
		else $error("middle short outside half bias");
	tick_pulse_a: assert property (frame_tick |->
		driver_active ##1 !frame_tick)
		else $error("frame tick wide or while idle");
endmodule
bind lcb_ctrl lcb_ctrl_props i_props (.clock, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_tick,
	.driver_active, .internal_ref_on, .ref_from_fvr, .ref_from_supply,
	.bandgap_buf_en, .fvr_buf_en, .contrast_ladder_on, .contrast_select,
	.ladder_power, .ladder_mid_short, .bias_type, .segment_enable_bit);
`default_nettype wire

//--- tb/lcb_far.sv
// far side model: the two free oscillators feeding the lcd clock.
// assumes periods are whole multiples of the 10 ns system clock.
`timescale 1ns/1ps
`default_nettype none
// ====================
// oscillator sources
module lcb_far #(
	parameter XT_HALF = 100,
	parameter LF_HALF = 150
) (
	// software crystal enable
	input  wire logic crystal_osc_enable,
	// oscillator pins
	output var logic  crystal_osc_clock,
	output var logic  low_freq_internal_osc
);
	// odd start offset keeps edges away from the system clock edge
	// crystal idle until enabled
	initial begin
		crystal_osc_clock = 1'b0;
		#3;
		forever #XT_HALF crystal_osc_clock =
			crystal_osc_enable & ~crystal_osc_clock;
	end
	// low oscillator always runs
	initial begin
		low_freq_internal_osc = 1'b0;
		#7;
		forever #LF_HALF low_freq_internal_osc = ~low_freq_internal_osc;
	end
endmodule
`default_nettype wire

//--- tb/lcb_ctrl_bench.sv
// self-checking bench for lcb_ctrl.
// assumes the register map header and the oscillator model.
`timescale 1ns/1ps
`default_nettype none
`include "lcb_regs.vh"
module lcb_ctrl_bench;
	// ====================
	// signals
	logic        clock, rst_n, reg_wr, reg_rd, sleep_mode, ladder_phase_b;
	logic        xt_en, frame_tick, driver_active, internal_ref_on;
	logic        ref_from_fvr, ref_from_supply, bandgap_buf_en, fvr_buf_en;
	logic        contrast_ladder_on, ladder_mid_short;
	logic        crystal_osc_clock, low_freq_internal_osc;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [2:0]  contrast_select;
	logic [3:1]  bias_pin_connect;
	logic [1:0]  ladder_power, bias_type, commons_select;
	logic [15:0] segment_enable_bit;
	logic [63:0] pixel_bit, pix;
	int          error_cnt, n_checks, tick_n;

	lcb_ctrl i_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .crystal_osc_clock, .low_freq_internal_osc,
		.sleep_mode, .ladder_phase_b, .frame_tick, .driver_active,
		.internal_ref_on, .ref_from_fvr, .ref_from_supply, .bandgap_buf_en,
		.fvr_buf_en, .contrast_ladder_on, .contrast_select,
		.bias_pin_connect, .ladder_power, .ladder_mid_short, .bias_type,
		.commons_select, .segment_enable_bit, .pixel_bit);
	lcb_far i_far (.crystal_osc_enable(xt_en), .crystal_osc_clock,
		.low_freq_internal_osc);

	// ====================
	// helpers
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task gap(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// write: one strobe cycle, register fields settled on return; driver_active a cycle later
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask
	// read data stands only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	// strictly the next frame tick, bounded so a dead source cannot hang
	task wait_tick;
		tick_n = 0;
		do begin
			@(negedge clock);
			tick_n++;
		end while (frame_tick !== 1'b1 && tick_n < 5000);
	endtask
	// clocks between the next two frame ticks
	task tick_gap(input int exp);
		wait_tick;
		wait_tick;
		chk(tick_n, exp);
	endtask

	// ====================
	// scenarios
	task t_reset;
		rd(4'h0, 8'h00);
		rd(4'hC, 8'h03);
		rd(4'hD, 8'h03);
		rd(4'hF, 8'h00);
		chk(ladder_power, 2'h0);
		chk(driver_active, 1'b0);
		chk(commons_select, 2'h3);
		chk(bias_type, 2'h2);
		$display("test reset done");
	endtask
	task t_ref;
		wr(4'h0, 8'hFF);
		rd(4'h0, 8'hEE);
		chk(bias_pin_connect, 3'h7);
		wr(4'hC, 8'h80);
		gap(2);
		chk({internal_ref_on, ref_from_fvr, ref_from_supply}, 3'h6);
		@(posedge clock);
		ladder_phase_b <= 1'b1;
		gap(1);
		chk(fvr_buf_en, 1'b0);
		wr(4'h0, 8'hC0);
		chk(fvr_buf_en, 1'b1);
		wr(4'h0, 8'h80);
		chk({internal_ref_on, ref_from_supply}, 2'h3);
		wr(4'h0, 8'h40);
		chk({internal_ref_on, bandgap_buf_en, contrast_ladder_on}, 3'h0);
		$display("test reference done");
	endtask
	task t_contrast;
		for (int i = 0; i < 8; i++) begin
			wr(4'h1, 8'hF8 | i[7:0]);
			chk(contrast_select, i[2:0]);
			rd(4'h1, i[7:0]);
		end
		$display("test contrast done");
	endtask
	task t_ladder;
		wr(4'hE, 8'h03);
		wr(4'hC, 8'h81);
		chk(ladder_power, 2'h3);
		chk(commons_select, 2'h1);
		chk(driver_active, 1'b1);
		wr(4'hD, 8'h60);
		chk({bias_type, ladder_mid_short}, 3'h3);
		rd(4'hD, 8'h60);
		wr(4'hD, 8'h00);
		chk({bias_type, ladder_mid_short}, 3'h4);
		wr(4'hC, 8'h00);
		gap(2);
		chk(ladder_power, 2'h0);
		chk(driver_active, 1'b0);
		rd(4'hD, 8'h00);
		$display("test ladder done");
	endtask
	task t_pixels;
		wr(4'h2, 8'hA5);
		wr(4'h3, 8'h5A);
		chk(segment_enable_bit, 16'h5AA5);
		for (int k = 0; k < 8; k++) begin
			pix[8*k +: 8] = {k[3:0], ~k[3:0]};
			wr(4'h4 + k[3:0], pix[8*k +: 8]);
		end
		chk(pixel_bit, pix);
		// mid-run reset, driven on rising edges like every input except the two oscillator pins
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		gap(1);
		chk(pixel_bit, pix);
		chk(segment_enable_bit, 16'h0000);
		$display("test pixels done");
	endtask
	task t_frame;
		wr(4'hC, 8'h80);
		wr(4'hD, 8'h00);
		tick_gap(256);
		wr(4'hD, 8'h01);
		tick_gap(512);
		wr(4'hD, 8'h0F);
		tick_gap(4096);
		wr(4'hD, 8'h00);
		@(posedge clock);
		xt_en <= 1'b1;
		wr(4'hC, 8'h84);
		// the switch itself lands on a last system-divider frame
		wait_tick;
		tick_gap(20);
		@(posedge clock);
		sleep_mode <= 1'b1;
		tick_gap(20);
		wr(4'hC, 8'h88);
		// last crystal frame carries the switch to the low oscillator
		wait_tick;
		tick_gap(30);
		wr(4'hC, 8'h8C);
		tick_gap(30);
		// sleep disable bit stops the driver while asleep
		wr(4'hC, 8'hCC);
		gap(1);
		chk(driver_active, 1'b0);
		$display("test frame done");
	endtask

	// ====================
	// clock, watchdog and main sequence
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#300_000;
		error_cnt++;
		summarize;
	end
	initial begin
		{rst_n, reg_wr, reg_rd, sleep_mode, ladder_phase_b, xt_en} = 6'h00;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		error_cnt = 0;
		n_checks = 0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		t_reset;
		t_ref;
		t_contrast;
		t_ladder;
		t_pixels;
		t_frame;
		summarize;
	end
endmodule
`default_nettype wire
